// [hdl/hebb_bridge.sv]
// Purpose: Forward host accesses in the expansion window to byte-wide peripherals
// Assumes: Core request port on core_clk; bus logic on the host bus clock
// Notes:   Strobe width is fixed by DATA_CYCLES; peripherals cannot extend it
// What this block does
// - Low driven pins go high before floating
// - Expansion clock is inverted host bus clock
// - Address phase drives bus bits 31:18 zero
// - Only base-address matches reach the expansion bus
// - Data phase passes 32 data bits unaltered
// - Each lane select chooses one byte lane
// - Lane selects copy data-phase byte enables only
// - Lane selects high outside the data phase
// - Default write strobe low, rising edge writes
// - Alternate mode read/write level spans address through data
// - Read strobe or data strobe low when due
// - Address latch low from latch through data
// - Drive bus only under hold grant
`timescale 1ns/1ns
module hebb_bridge
  import hebb_pkg::*;
#(
  parameter int DATA_CYCLES = DATA_CYCLES_DEF
)
(
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire logic                 host_bus_clk,
  input  wire logic [BASE_W-1:0]    expansion_base,
  input  wire logic                 alt_mode,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [31:0]          req_addr,
  input  wire logic [LANES-1:0]     req_byte_en_n,
  input  wire logic                 req_write,
  input  wire logic [31:0]          req_wdata,
  output logic                      resp_valid,
  output logic                      resp_miss,
  output logic [31:0]               resp_rdata,
  output logic                      expansion_clock_out,
  output logic                      hold_request,
  input  wire logic                 bus_hold_grant,
  input  wire logic [EXP_BUS_W-1:0] exp_addr_data_in,
  output logic [EXP_BUS_W-1:0]      exp_addr_data_out,
  output logic                      exp_addr_data_oe,
  output logic [LANES-1:0]          exp_lane_select_n,
  output logic                      exp_lane_select_oe,
  output logic                      write_strobe_n,
  output logic                      write_strobe_oe,
  output logic                      data_strobe_n,
  output logic                      data_strobe_oe,
  output logic                      addr_latch_n,
  output logic                      addr_latch_oe
);

  // Read data is sampled through two flops, so the strobe must outlast them
  if (DATA_CYCLES < MIN_DATA_CYCLES || DATA_CYCLES > MAX_DATA_CYCLES)
  begin : g_bad_cycles
    $error("DATA_CYCLES out of the range the bridge can serve");
  end

  localparam logic [CNT_W-1:0] DATA_LAST = CNT_W'(DATA_CYCLES - 1);

  // Window match on the upper host address bits
  function automatic logic in_window(input logic [31:0] a, input logic [BASE_W-1:0] b);
    in_window = (a[31:BASE_LSB] == b);
  endfunction

  // Clock to the peripherals is the host bus clock turned over
  assign expansion_clock_out = ~host_bus_clk;

  // Core side state
  hebb_core_state_e c_state;
  hebb_core_state_e next_c_state;
  logic             req_tog;
  logic             next_req_tog;
  logic             ack_seen;
  logic             next_ack_seen;
  logic             ack_tog_s;
  logic [31:0]      c_addr;
  logic [31:0]      next_c_addr;
  logic [LANES-1:0] c_be_n;
  logic [LANES-1:0] next_c_be_n;
  logic             c_write;
  logic             next_c_write;
  logic [31:0]      c_wdata;
  logic [31:0]      next_c_wdata;
  logic             next_resp_valid;
  logic             next_resp_miss;
  logic [31:0]      next_resp_rdata;
  logic             hit;

  // Link side state
  hebb_link_state_e       l_state;
  hebb_link_state_e       next_l_state;
  logic                   l_rst_n;
  logic                   grant_s;
  logic                   alt_s;
  logic                   req_tog_s;
  logic [EXP_BUS_W-1:0]   din_s;
  logic                   req_seen;
  logic                   next_req_seen;
  logic                   ack_tog;
  logic                   next_ack_tog;
  logic [CNT_W-1:0]       cnt;
  logic [CNT_W-1:0]       next_cnt;
  logic [EXP_ADDR_W-1:0]  l_addr;
  logic [EXP_ADDR_W-1:0]  next_l_addr;
  logic [LANES-1:0]       l_be_n;
  logic [LANES-1:0]       next_l_be_n;
  logic                   l_write;
  logic                   next_l_write;
  logic                   l_alt;
  logic                   next_l_alt;
  logic [31:0]            l_wdata;
  logic [31:0]            next_l_wdata;
  logic [31:0]            l_rdata;
  logic [31:0]            next_l_rdata;
  logic [EXP_BUS_W-1:0]   next_dout;
  logic                   next_dout_oe;
  logic [LANES-1:0]       next_lanes;
  logic                   next_lanes_oe;
  logic                   own;
  logic                   ale_on;
  logic                   wr_on;
  logic                   ds_on;

  // Crossings: reset, grant, mode and request toggle into the link domain
  hebb_sync #(.W(1)) u_sync_rst (
    .clk   (host_bus_clk),
    .rst_n (1'b1),
    .d     (reset_n),
    .q     (l_rst_n)
  );

  hebb_sync #(.W(3)) u_sync_ctl (
    .clk   (host_bus_clk),
    .rst_n (l_rst_n),
    .d     ({bus_hold_grant, alt_mode, req_tog}),
    .q     ({grant_s, alt_s, req_tog_s})
  );

  // Read data pin passes two flops before it is captured
  hebb_sync #(.W(EXP_BUS_W)) u_sync_din (
    .clk   (host_bus_clk),
    .rst_n (l_rst_n),
    .d     (exp_addr_data_in),
    .q     (din_s)
  );

  // Completion toggle back into the core domain
  hebb_sync #(.W(1)) u_sync_ack (
    .clk   (core_clk),
    .rst_n (reset_n),
    .d     (ack_tog),
    .q     (ack_tog_s)
  );

  // Core side: accept, filter by window, then wait for the link to finish
  always_comb
  begin
    hit             = in_window(req_addr, expansion_base);
    req_ready       = (c_state == C_IDLE) && !resp_valid;
    next_c_state    = c_state;
    next_req_tog    = req_tog;
    next_ack_seen   = ack_seen;
    next_c_addr     = c_addr;
    next_c_be_n     = c_be_n;
    next_c_write    = c_write;
    next_c_wdata    = c_wdata;
    next_resp_valid = 1'b0;
    next_resp_miss  = 1'b0;
    next_resp_rdata = resp_rdata;
    unique case (c_state)
      C_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          if (hit)
          begin
            next_c_addr  = req_addr;
            next_c_be_n  = req_byte_en_n;
            next_c_write = req_write;
            next_c_wdata = req_wdata;
            next_req_tog = ~req_tog;
            next_c_state = C_WAIT;
          end
          else
          begin
            // Outside the window: answered at once, the bus never moves
            next_resp_valid = 1'b1;
            next_resp_miss  = 1'b1;
          end
        end
      end
      C_WAIT:
      begin
        // Link holds its read word stable until the next request
        if (ack_tog_s != ack_seen)
        begin
          next_ack_seen   = ack_tog_s;
          next_resp_valid = 1'b1;
          next_resp_rdata = l_rdata;
          next_c_state    = C_IDLE;
        end
      end
    endcase
    if (!reset_n)
    begin
      next_c_state    = C_IDLE;
      next_req_tog    = 1'b0;
      next_ack_seen   = 1'b0;
      next_c_addr     = 32'h0;
      next_c_be_n     = LANES_OFF;
      next_c_write    = 1'b0;
      next_c_wdata    = 32'h0;
      next_resp_valid = 1'b0;
      next_resp_rdata = 32'h0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    c_state    <= next_c_state;
    req_tog    <= next_req_tog;
    ack_seen   <= next_ack_seen;
    c_addr     <= next_c_addr;
    c_be_n     <= next_c_be_n;
    c_write    <= next_c_write;
    c_wdata    <= next_c_wdata;
    resp_valid <= next_resp_valid;
    resp_miss  <= next_resp_miss;
    resp_rdata <= next_resp_rdata;
  end

  // Link sequence: request bus, address, latch, data, recovery
  always_comb
  begin
    next_l_state  = l_state;
    next_req_seen = req_seen;
    next_ack_tog  = ack_tog;
    next_cnt      = cnt;
    next_l_addr   = l_addr;
    next_l_be_n   = l_be_n;
    next_l_write  = l_write;
    next_l_alt    = l_alt;
    next_l_wdata  = l_wdata;
    next_l_rdata  = l_rdata;
    unique case (l_state)
      L_IDLE:
      begin
        // Core words are stable while its toggle is in flight
        if (req_tog_s != req_seen)
        begin
          next_req_seen = req_tog_s;
          next_l_addr   = c_addr[HOST_ADDR_LSB +: EXP_ADDR_W];
          next_l_be_n   = c_be_n;
          next_l_write  = c_write;
          next_l_wdata  = c_wdata;
          next_l_alt    = alt_s;
          next_l_state  = L_REQ;
        end
      end
      L_REQ:
      begin
        if (grant_s)
        begin
          next_l_state = L_ADDR;
        end
      end
      L_ADDR:
      begin
        next_l_state = L_LATCH;
      end
      L_LATCH:
      begin
        next_cnt     = DATA_LAST;
        next_l_state = L_DATA;
      end
      L_DATA:
      begin
        if (cnt == '0)
        begin
          if (!l_write)
          begin
            next_l_rdata = din_s;
          end
          next_l_state = L_RECOV;
        end
        else
        begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      L_RECOV:
      begin
        next_ack_tog = ~ack_tog;
        next_l_state = L_IDLE;
      end
      default:
      begin
        next_l_state = L_IDLE;
      end
    endcase
    if (!l_rst_n)
    begin
      next_l_state  = L_IDLE;
      next_req_seen = 1'b0;
      next_ack_tog  = 1'b0;
      next_cnt      = '0;
      next_l_addr   = '0;
      next_l_be_n   = LANES_OFF;
      next_l_write  = 1'b0;
      next_l_alt    = 1'b0;
      next_l_wdata  = 32'h0;
      next_l_rdata  = 32'h0;
    end
  end

  // Bus word and lane selects are registered from the next state
  always_comb
  begin
    next_dout     = '0;
    next_dout_oe  = 1'b0;
    next_lanes    = LANES_OFF;
    next_lanes_oe = (next_l_state inside {L_ADDR, L_LATCH, L_DATA, L_RECOV});
    if (next_l_state inside {L_ADDR, L_LATCH})
    begin
      next_dout    = {{(EXP_BUS_W-EXP_ADDR_W){1'b0}}, next_l_addr};
      next_dout_oe = 1'b1;
    end
    else if ((next_l_state inside {L_DATA, L_RECOV}) && next_l_write)
    begin
      // Held into recovery so the strobe's rising edge sees stable data
      next_dout    = next_l_wdata;
      next_dout_oe = 1'b1;
    end
    if (next_l_state == L_DATA)
    begin
      next_lanes = next_l_be_n;
    end
  end

  always_ff @(posedge host_bus_clk)
  begin
    l_state            <= next_l_state;
    req_seen           <= next_req_seen;
    ack_tog            <= next_ack_tog;
    cnt                <= next_cnt;
    l_addr             <= next_l_addr;
    l_be_n             <= next_l_be_n;
    l_write            <= next_l_write;
    l_alt              <= next_l_alt;
    l_wdata            <= next_l_wdata;
    l_rdata            <= next_l_rdata;
    exp_addr_data_out  <= next_dout;
    exp_addr_data_oe   <= next_dout_oe;
    exp_lane_select_n  <= next_lanes;
    exp_lane_select_oe <= next_lanes_oe;
  end

  // Strobe intent per state; pins float whenever the bus is not ours
  always_comb
  begin
    own          = (l_state inside {L_ADDR, L_LATCH, L_DATA, L_RECOV});
    hold_request = (l_state != L_IDLE);
    ale_on       = (l_state inside {L_LATCH, L_DATA});
    // Alternate mode keeps the read/write level from the address phase through the data phase
    wr_on        = l_alt ? (l_write && (l_state != L_RECOV))
                         : (l_write && (l_state == L_DATA));
    ds_on        = (l_state == L_DATA) && (l_alt || !l_write);
  end

  hebb_sts_pin u_pin_wr (
    .clk        (host_bus_clk),
    .rst_n      (l_rst_n),
    .own        (own),
    .assert_low (wr_on),
    .pin_n      (write_strobe_n),
    .pin_oe     (write_strobe_oe)
  );

  hebb_sts_pin u_pin_ds (
    .clk        (host_bus_clk),
    .rst_n      (l_rst_n),
    .own        (own),
    .assert_low (ds_on),
    .pin_n      (data_strobe_n),
    .pin_oe     (data_strobe_oe)
  );

  hebb_sts_pin u_pin_ale (
    .clk        (host_bus_clk),
    .rst_n      (l_rst_n),
    .own        (own),
    .assert_low (ale_on),
    .pin_n      (addr_latch_n),
    .pin_oe     (addr_latch_oe)
  );

  // Checks on the link side
  a_addr_upper_zero: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    (l_state == L_LATCH) |-> (exp_addr_data_oe && exp_addr_data_out[31:18] == 14'h0))
    else $error("upper address bits not zero");

  a_addr_low_bits: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    (l_state == L_LATCH) |-> (exp_addr_data_out[17:0] == $past(l_addr)))
    else $error("address phase word wrong");

  a_write_data_pass: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    (l_state == L_DATA && l_write) |-> (exp_addr_data_oe && exp_addr_data_out == l_wdata))
    else $error("write data altered");

  a_lanes_data_only: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    (l_state != L_DATA) |-> (exp_lane_select_n == 4'hF))
    else $error("lane select low outside data phase");

  a_lanes_from_be: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    (l_state == L_DATA) |-> (exp_lane_select_n == l_be_n && exp_lane_select_oe))
    else $error("lane selects not the byte enables");

  a_float_unowned: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    !own |-> (!exp_addr_data_oe && !exp_lane_select_oe))
    else $error("bus driven while not owned");

  a_addr_then_data: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    $rose(l_state == L_DATA) |-> ($past(l_state, 1) == L_LATCH && $past(l_state, 2) == L_ADDR))
    else $error("data phase without address phase");

  a_grant_first: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    $rose(own) |-> $past(grant_s))
    else $error("bus taken without grant");

  a_strobe_low_data: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    (l_state == L_DATA && (l_alt || !l_write)) |-> (!data_strobe_n && data_strobe_oe))
    else $error("data strobe not low in data phase");

  a_rw_level_held: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    (l_alt && l_write && l_state == L_ADDR) |-> (!write_strobe_n)[*2] ##1 !write_strobe_n)
    else $error("read/write level not held for write");

  a_wr_rise_data: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    (!l_alt && $rose(write_strobe_n) && l_write) |-> (exp_addr_data_oe && exp_addr_data_out == l_wdata))
    else $error("write data gone at strobe rise");

  a_latch_held: assert property (@(posedge host_bus_clk) disable iff (!l_rst_n)
    (l_state == L_DATA) |-> (!addr_latch_n && addr_latch_oe))
    else $error("address latch not low in data phase");

  // Checks on the core side
  a_miss_answered: assert property (@(posedge core_clk) disable iff (!reset_n)
    (req_valid && req_ready && !hit) |=> (resp_valid && resp_miss && $stable(req_tog)))
    else $error("miss not answered or forwarded");

  a_hit_forwarded: assert property (@(posedge core_clk) disable iff (!reset_n)
    (req_valid && req_ready && hit) |=> (req_tog != $past(req_tog) && c_state == C_WAIT))
    else $error("hit not forwarded");

endmodule // hebb_bridge

// [hdl/hebb_pkg.sv]
// Purpose: Shared constants and state types of the host to expansion bus bridge
// Assumes: Host addresses are 32-bit byte addresses, expansion bus is 32 bits wide
// Notes:   Address split, widths, lane and synchroniser reset values and data cycle limits of the bridge live here
package hebb_pkg;

  // Host address split: upper bits compared against the window base
  localparam int             BASE_W          = 12;
  localparam int             BASE_LSB        = 20;
  localparam int             HOST_ADDR_LSB   = 2;
  localparam int             EXP_ADDR_W      = 18;
  localparam int             EXP_BUS_W       = 32;
  localparam int             LANES           = 4;

  // Lane selects are active low; all ones means no lane chosen
  localparam logic [3:0]     LANES_OFF       = 4'hF;

  // Strobe width of the data phase in link clocks, and the least the read path can serve
  localparam int             DATA_CYCLES_DEF = 4;
  localparam int             MIN_DATA_CYCLES = 3;
  localparam int             MAX_DATA_CYCLES = 15;
  localparam int             CNT_W           = 4;

  // Value taken by synchroniser flops at reset
  localparam logic           SYNC_RST_VAL    = 1'b0;

  // Link side sequence of one expansion access
  typedef enum logic [2:0]
  {
    L_IDLE  = 3'b000,
    L_REQ   = 3'b001,
    L_ADDR  = 3'b010,
    L_LATCH = 3'b011,
    L_DATA  = 3'b100,
    L_RECOV = 3'b101
  } hebb_link_state_e;

  // Core side request tracking
  typedef enum logic [1:0]
  {
    C_IDLE = 2'b00,
    C_WAIT = 2'b01
  } hebb_core_state_e;

endpackage

// [hdl/hebb_sts_pin.sv]
// Purpose: Driver for one active-low sustained three-state pin
// Assumes: A pull-up outside holds the pin high while released
// Notes:   A pin driven low is driven high one more cycle before it floats
`timescale 1ns/1ns
module hebb_sts_pin
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic own,
  input  wire logic assert_low,
  output logic      pin_n,
  output logic      pin_oe
);

  logic was_low;
  logic next_was_low;

  // Remember a low drive so release is preceded by a high cycle
  always_comb
  begin
    next_was_low = rst_n & own & assert_low;
    pin_n        = ~(own & assert_low);
    pin_oe       = own | was_low;
  end

  always_ff @(posedge clk)
  begin
    was_low <= next_was_low;
  end

  a_high_before_release: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_oe && !pin_n) |=> (pin_oe && (pin_n || own)))
    else $error("pin floated straight from low");

endmodule // hebb_sts_pin

// [hdl/hebb_sync.sv]
// Purpose: Two flop synchroniser for levels and stable words
// Assumes: Multi-bit use only for words held stable while sampled
// Notes:   The first stage feeds the second stage and nothing else
`timescale 1ns/1ns
module hebb_sync
  import hebb_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  // Next values of both stages
  always_comb
  begin
    next_stage1 = rst_n ? d : {W{SYNC_RST_VAL}};
    next_q      = rst_n ? stage1 : {W{SYNC_RST_VAL}};
  end

  // Register only
  always_ff @(posedge clk)
  begin
    stage1 <= next_stage1;
    q      <= next_q;
  end

endmodule // hebb_sync

// [verification/hebb_bridge_tb.sv]
// Purpose: Self-checking bench of the bridge against peripheral and arbiter models
// Assumes: Inputs move 5 ns after the core clock edge
// Notes:   Shortest legal strobe width is used to stress the read path
`timescale 1ns/1ns
module hebb_bridge_tb
  import hebb_pkg::*;
();
  localparam logic [31:0] ADR_A = 32'h5A301234;
  localparam logic [31:0] ADR_B = 32'h5A3FFFFC;
  logic              core_clk = 1'b0;
  logic              host_bus_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              alt_mode = 1'b0;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [31:0]       req_addr = 32'h0;
  logic [31:0]       req_wdata = 32'h0;
  logic [LANES-1:0]  req_byte_en_n = 4'hF;
  logic [3:0]        gnt_dly = 4'h0;
  logic [BASE_W-1:0] expansion_base = 12'h5A3;
  logic              req_ready, resp_valid, resp_miss, expansion_clock_out, hold_request;
  logic              bus_hold_grant, d_oe, ln_oe, ws_n, ws_oe, ds_n, ds_oe, ale_n, ale_oe, viol;
  logic [31:0]       resp_rdata, bus, d_out, p_addr;
  logic [3:0]        ln_n, p_ln;
  int                err_count = 0;
  int                checks_done = 0;
  int                lat;
  int                fast;

  hebb_bridge #(.DATA_CYCLES(3)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .host_bus_clk(host_bus_clk), .expansion_base(expansion_base), .alt_mode(alt_mode),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .req_byte_en_n(req_byte_en_n), .req_write(req_write), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_miss(resp_miss), .resp_rdata(resp_rdata),
    .expansion_clock_out(expansion_clock_out), .hold_request(hold_request),
    .bus_hold_grant(bus_hold_grant), .exp_addr_data_in(bus), .exp_addr_data_out(d_out),
    .exp_addr_data_oe(d_oe), .exp_lane_select_n(ln_n), .exp_lane_select_oe(ln_oe),
    .write_strobe_n(ws_n), .write_strobe_oe(ws_oe), .data_strobe_n(ds_n),
    .data_strobe_oe(ds_oe), .addr_latch_n(ale_n), .addr_latch_oe(ale_oe));
  hebb_periph peri (.clk(host_bus_clk), .alt(alt_mode), .gnt_dly(gnt_dly),
    .hold(hold_request), .grant(bus_hold_grant), .d_out(d_out), .d_oe(d_oe), .bus(bus),
    .ln_n(ln_n), .ln_oe(ln_oe), .st_n({ale_n, ds_n, ws_n}), .st_oe({ale_oe, ds_oe, ws_oe}),
    .addr(p_addr), .ln_at_addr(p_ln), .viol(viol));

  // Clocks; the link clock is 15 ns with an odd phase
  always #50 core_clk = ~core_clk;
  always
  begin
    #7 host_bus_clk = 1'b1;
    #8 host_bus_clk = 1'b0;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One request held until an edge sees ready, then a bounded wait for the answer
  task automatic acc(input logic [31:0] a, input logic [3:0] be, input logic w,
                     input logic [31:0] wd);
    @(posedge core_clk);
    #5 req_valid = 1'b1;
    req_addr = a;
    req_byte_en_n = be;
    req_write = w;
    req_wdata = wd;
    do @(posedge core_clk); while (req_ready !== 1'b1);
    #5 req_valid = 1'b0;
    // The cycle right after the taking edge counts as one
    lat = 1;
    while (resp_valid !== 1'b1 && lat < 300)
    begin
      @(posedge core_clk);
      #1 lat++;
    end
    // A wait that runs out is a mismatch, not a silent pass
    chk("resp_valid", 1, resp_valid);
  endtask

  task automatic t_reset();
    repeat (10) @(posedge core_clk);
    #5 chk("ready", 1, req_ready);
    chk("resp_valid", 0, resp_valid);
    chk("hold", 0, hold_request);
    @(posedge host_bus_clk);
    #2 chk("expansion_clock_out hi", 0, expansion_clock_out);
    @(negedge host_bus_clk);
    #2 chk("expansion_clock_out lo", 1, expansion_clock_out);
    @(posedge core_clk);
    #5 reset_n = 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // Addresses just outside the window either side
  task automatic t_miss();
    acc(32'h5A400000, 4'h0, 1'b1, 32'h0);
    chk("miss lat", 1, lat);
    chk("miss hi", 1, resp_miss);
    acc(32'h5A2FFFFC, 4'h0, 1'b0, 32'h0);
    chk("miss lo", 1, resp_miss);
    chk("miss hold", 0, hold_request);
  endtask

  task automatic t_write();
    acc(ADR_A, 4'h0, 1'b1, 32'h11223344);
    chk("hit", 0, resp_miss);
    chk("addr", {14'h0, ADR_A[19:2]}, p_addr);
    chk("lanes addr", 4'hF, p_ln);
    acc(ADR_A, 4'hA, 1'b1, 32'hAABBCCDD);
    acc(ADR_A, 4'h0, 1'b0, 32'h0);
    fast = lat;
    chk("rd mix", 32'h11BB33DD, resp_rdata);
  endtask

  task automatic t_alt();
    @(posedge core_clk);
    #5 alt_mode = 1'b1;
    acc(ADR_B, 4'h0, 1'b1, 32'h5E6F7081);
    acc(ADR_B, 4'h0, 1'b0, 32'h0);
    chk("alt rd", 32'h5E6F7081, resp_rdata);
    chk("alt addr", {14'h0, ADR_B[19:2]}, p_addr);
    acc(ADR_A, 4'h0, 1'b0, 32'h0);
    chk("alt rd a", 32'h11BB33DD, resp_rdata);
  endtask

  // Slow arbiter: nothing may be driven before the grant
  task automatic t_slow();
    @(posedge core_clk);
    #5 alt_mode = 1'b0;
    gnt_dly = 4'h9;
    acc(ADR_B, 4'h0, 1'b0, 32'h0);
    chk("slow rd", 32'h5E6F7081, resp_rdata);
    chk("slow lat", 1, lat > fast);
    chk("viol", 0, viol);
  endtask

  task automatic test_done();
    $display("checks_done %0d err_count %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    t_reset();
    t_miss();
    t_write();
    t_alt();
    t_slow();
    test_done();
  end
  // Watchdog: far beyond nine accesses of under a microsecond each
  initial
  begin
    #2000000;
    err_count++;
    $display("Error watchdog expected done seen timeout");
    test_done();
  end
endmodule // hebb_bridge_tb

// [verification/hebb_periph.sv]
// Purpose: Byte-wide peripherals and bus arbiter on the far side of the bridge
// Assumes: Pull-ups on the strobes; the data bus floats to a pattern toggling each cycle
// Notes:   viol is sticky and set by any protocol slip seen on the wire
`timescale 1ns/1ns
module hebb_periph
(
  input  wire logic        clk,
  input  wire logic        alt,
  input  wire logic [3:0]  gnt_dly,
  input  wire logic        hold,
  output logic             grant,
  input  wire logic [31:0] d_out,
  input  wire logic        d_oe,
  output logic [31:0]      bus,
  input  wire logic [3:0]  ln_n,
  input  wire logic        ln_oe,
  input  wire logic [2:0]  st_n,
  input  wire logic [2:0]  st_oe,
  output logic [31:0]      addr,
  output logic [3:0]       ln_at_addr,
  output logic             viol
);
  logic [7:0]  mem [4][16];
  logic [3:0]  cnt = 4'h0;
  logic [31:0] pat = 32'hAAAAAAAA;
  logic [31:0] pend_d;
  logic [3:0]  pend_l;
  logic [2:0]  st;
  logic [2:0]  last_n = 3'h7;
  logic [2:0]  last_oe = 3'h0;
  logic [3:0]  ln;
  logic        rd;
  logic        wr;

  initial
  begin
    grant = 1'b0;
    viol = 1'b0;
  end
  // Strobes are {latch, data, write}; pull-ups hold them high once released
  assign st = st_n | ~st_oe;
  assign ln = ln_oe ? ln_n : pat[3:0];
  assign rd = ~st[1] & (~alt | st[0]);
  assign wr = alt ? (~st[1] & ~st[0]) : ~st[0];
  // Selected lanes answer a read; floating bits never repeat a stale value
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      bus[8*k+:8] = d_oe ? d_out[8*k+:8] : (rd & ~ln[k]) ? mem[k][addr[3:0]] : pat[8*k+:8];
  end
  // Grant after gnt_dly+1 cycles of hold request, dropped one cycle after it
  always @(posedge clk)
  begin
    cnt <= hold ? cnt + {3'h0, cnt != 4'hF} : 4'h0;
    grant <= hold && (cnt >= gnt_dly);
    pat <= ~pat;
  end
  // Address taken on the falling latch
  always @(negedge st[2])
  begin
    addr <= bus;
    ln_at_addr <= ln;
  end
  // Mid-cycle sampling keeps clear of the edges where outputs move
  always @(negedge clk)
  begin
    if (wr)
    begin
      pend_d <= bus;
      pend_l <= ln;
    end
    if (|(last_oe & ~st_oe & ~last_n)) viol <= 1'b1;
    if ((d_oe | ln_oe | (|st_oe)) & ~grant) viol <= 1'b1;
    if (~st[1] & st[2]) viol <= 1'b1;
    if (ln_oe & (ln_n != 4'hF) & st[1] & (alt | st[0])) viol <= 1'b1;
    last_n <= st_n;
    last_oe <= st_oe;
  end
  // The write takes effect as the strobe rises
  always @(negedge wr)
  begin
    for (int k = 0; k < 4; k++)
      if (!pend_l[k]) mem[k][addr[3:0]] <= pend_d[8*k+:8];
  end
endmodule // hebb_periph
